//--- logic/clock_source_switchover.v
`timescale 1ns/10ps
`include "clk_switch_consts.vh"
module clock_source_switchover #(
    parameter TIMEOUT = `TIMEOUT_CYCLES,
    parameter TRIM_W = `TRIM_WIDTH
) (
    clk,
    rst_n,
    ce,
    otp_valid,
    otp_trim,
    ext_clk_in,
    osc_trim,
    ext_selected,
    timing_tick,
    fallback_pulse
);
    input wire clk;
    input wire rst_n;
    input wire ce;
    input wire otp_valid;
    input wire [TRIM_W-1:0] otp_trim;
    input wire ext_clk_in;
    output reg [TRIM_W-1:0] osc_trim;
    output reg ext_selected;
    output reg timing_tick;
    output reg fallback_pulse;

    localparam CW = $clog2(TIMEOUT + 1);
    localparam integer TERM_I = TIMEOUT - 1;
    localparam integer ONE_I = 1;
    localparam [CW-1:0] TERM = TERM_I[CW-1:0];
    localparam [CW-1:0] CNT_ONE = ONE_I[CW-1:0];
    localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
    localparam [TRIM_W-1:0] TRIM_RST = `TRIM_DEFAULT;
    localparam [1:0] ST_INT = `ST_INT;
    localparam [1:0] ST_EXT = `ST_EXT;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg ext_prev_r;
    reg trim_loaded_r;
    reg trim_loaded_nxt;
    reg [TRIM_W-1:0] trim_nxt;
    reg [CW-1:0] idle_cnt_r;
    reg [CW-1:0] idle_cnt_nxt;
    reg sel_nxt;
    reg tick_nxt;
    reg fallback_nxt;
    wire ext_rise;
    wire in_ext;
    wire idle_full;

    // Reset low matches the tied-low idle level, so no false edge follows reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_r <= 1'b0;
        end else if (ce) begin
            ext_prev_r <= ext_clk_in;
        end
    end

    // Pin is taken as synchronous; edge seen on internal clock samples
    assign ext_rise = ext_clk_in & ~ext_prev_r;

    assign in_ext = (state_r == ST_EXT);

    assign idle_full = (idle_cnt_r == TERM);

    // A rise in the last idle cycle still counts as activity
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_INT: begin
                if (ext_rise) begin
                    state_nxt = ST_EXT; // [R4] [R2]
                end
            end
            ST_EXT: begin
                if (!ext_rise && idle_full) begin
                    state_nxt = ST_INT; // [R5] [R9]
                end
            end
            default: begin
                state_nxt = ST_INT;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_INT; // [R1]
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    always @* begin
        idle_cnt_nxt = CNT_ZERO;
        case (state_r)
            ST_EXT: begin
                if (ext_rise) begin
                    idle_cnt_nxt = CNT_ZERO; // [R9]
                end else if (idle_full) begin
                    idle_cnt_nxt = idle_cnt_r;
                end else begin
                    idle_cnt_nxt = idle_cnt_r + CNT_ONE; // [R9]
                end
            end
            default: begin
                idle_cnt_nxt = CNT_ZERO;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_r <= CNT_ZERO;
        end else if (ce) begin
            idle_cnt_r <= idle_cnt_nxt;
        end
    end

    // One-shot load; later changes of the memory port are ignored
    always @* begin
        trim_nxt = osc_trim;
        trim_loaded_nxt = trim_loaded_r;
        if (!trim_loaded_r && otp_valid) begin
            trim_nxt = otp_trim; // [R1] [R3]
            trim_loaded_nxt = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_trim <= TRIM_RST; // [R1]
        end else if (ce) begin
            osc_trim <= trim_nxt;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_loaded_r <= 1'b0;
        end else if (ce) begin
            trim_loaded_r <= trim_loaded_nxt;
        end
    end

    always @* begin
        sel_nxt = 1'b0;
        case (state_nxt)
            ST_EXT: begin
                sel_nxt = 1'b1; // [R4]
            end
            ST_INT: begin
                sel_nxt = 1'b0; // [R2]
            end
            default: begin
                sel_nxt = 1'b0;
            end
        endcase
    end

    // Pulse marks the single cycle in which the timeout takes effect
    always @* begin
        fallback_nxt = 1'b0;
        case (state_r)
            ST_EXT: begin
                if (state_nxt == ST_INT) begin
                    fallback_nxt = 1'b1; // [R5]
                end
            end
            ST_INT: begin
                fallback_nxt = 1'b0;
            end
            default: begin
                fallback_nxt = 1'b0;
            end
        endcase
    end

    // One tick per selected-clock period drives downstream timers
    always @* begin
        tick_nxt = 1'b1;
        case (state_r)
            ST_EXT: begin
                tick_nxt = ext_rise; // [R6]
            end
            ST_INT: begin
                tick_nxt = 1'b1; // [R6]
            end
            default: begin
                tick_nxt = 1'b1;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_selected <= 1'b0;
        end else if (ce) begin
            ext_selected <= sel_nxt;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallback_pulse <= 1'b0;
        end else if (ce) begin
            fallback_pulse <= fallback_nxt;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_tick <= 1'b0;
        end else if (ce) begin
            timing_tick <= tick_nxt;
        end
    end
endmodule

//--- common/clk_switch_consts.vh
// Behaviour
// R1: Power-up loads defaults; trim value and enables come from one-time memory. Here only the trim is loaded, once per reset on otp_valid.
// R2: External clock pin held low keeps all logic on internal oscillator.
// R3: Oscillator trim value from one-time memory sets nominal 12MHz frequency.
// R4: First rising edge on external pin switches the operating clock to it.
// R5: No external edge within 32 internal cycles returns to internal oscillator.
// R6: Selected clock times chopper, blank time, standstill delay, step generator.
// R7: Controller holds all digital inputs low while cycling the I/O supply.
// R8: External source runs 10-16 MHz, up to 18 MHz at 50% duty.
// R9: Timeout counter on internal clock, cleared per edge, falls back at terminal.
`ifndef CLK_SWITCH_CONSTS_VH
`define CLK_SWITCH_CONSTS_VH
`define TIMEOUT_CYCLES 32
`define TRIM_WIDTH 8
`define TRIM_DEFAULT 8'h80
`define NOMINAL_OSC_KHZ 12000
`define ST_INT 2'b01
`define ST_EXT 2'b10
`endif

//--- sim/ext_clk_src.sv
`timescale 1ns/10ps
module ext_clk_src (
    input wire run,
    output logic ext
);
    // Offset keeps pin changes away from both clock edges; stops low when idle
    initial begin
        ext = 1'b0;
        #2;
        forever #40 ext = run ? ~ext : 1'b0;
    end
endmodule

//--- sim/switch_properties.sv
`timescale 1ns/10ps
module switch_chk #(
    parameter int TIMEOUT = 32
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire ext_clk_in,
    input wire ext_selected,
    input wire timing_tick,
    input wire fallback_pulse
);
    logic prev_r;
    logic [7:0] quiet_r;
    logic rise;
    assign rise = ext_clk_in & ~prev_r;
    // Enabled cycles since the last sampled rise, saturating
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            quiet_r <= 8'h00;
        end else if (ce) begin
            prev_r <= ext_clk_in;
            if (rise) begin
                quiet_r <= 8'h00;
            end else if (quiet_r != 8'hFF) begin
                quiet_r <= quiet_r + 8'h01;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    go_ext_a: assert property (ce && rise |=> ext_selected)
        else $error("no switch");
    stay_int_a: assert property (ce && !ext_selected && !ext_clk_in |=> !ext_selected)
        else $error("left internal");
    fall_back_a: assert property ($fell(ext_selected) |-> fallback_pulse)
        else $error("no pulse");
    hold_ext_a: assert property (ce && ext_selected && quiet_r < TIMEOUT - 1 |=> ext_selected)
        else $error("early fallback");
    time_out_a: assert property (ce && ext_selected && !rise && quiet_r == TIMEOUT - 1
        |=> !ext_selected && fallback_pulse)
        else $error("late fallback");
    tick_int_a: assert property (ce && !ext_selected |=> timing_tick)
        else $error("missing tick");
    cover property ($rose(ext_selected));
    cover property (fallback_pulse);
    cover property (ext_selected && !ext_clk_in);
endmodule
bind clock_source_switchover switch_chk #(.TIMEOUT(TIMEOUT)) i_chk (.*);

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk = 0;
    logic rst_n = 0;
    logic ce = 0;
    logic otp_valid = 0;
    logic [7:0] otp_trim = 8'h00;
    logic run = 0;
    logic ext;
    logic sel;
    logic tick;
    logic fall;
    logic [7:0] trim;
    int miscompares = 0;
    int checked = 0;
    int count;
    initial forever #5 clk = ~clk;
    ext_clk_src i_src (.run(run), .ext(ext));
    clock_source_switchover i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .otp_valid(otp_valid),
        .otp_trim(otp_trim), .ext_clk_in(ext), .osc_trim(trim), .ext_selected(sel),
        .timing_tick(tick), .fallback_pulse(fall));
    task chk(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        miscompares += int'(g !== e);
        if (g !== e) $display("wrong value %s exp %h got %h", n, e, g);
    endtask
    task conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Reset, enable, OTP inputs and run are held low through reset, then trim arrives after release
    task t_reset;
        rst_n = 0;
        ce = 0;
        otp_valid = 0;
        otp_trim = 8'h00;
        run = 0;
        repeat (16) @(negedge clk);
        chk("trim", 8'h80, trim);
        chk("sel", 8'h0, sel);
        rst_n = 1;
        @(negedge clk);
        ce = 1;
        otp_trim = 8'h5A;
        otp_valid = 1;
        @(negedge clk);
        chk("trim", 8'h5A, trim);
        otp_trim = 8'hC3;
        repeat (4) @(negedge clk);
        chk("trim", 8'h5A, trim);
        chk("sel", 8'h0, sel);
        chk("tick", 8'h1, tick);
    endtask
    // Source stops low, so only the idle counter can bring it back
    task t_switch;
        run = 1;
        repeat (12) @(negedge clk);
        chk("sel", 8'h1, sel);
        count = 0;
        repeat (80) begin
            @(negedge clk);
            count += tick;
        end
        chk("ticks", 8'h0A, count[7:0]);
        run = 0;
        repeat (24) @(negedge clk);
        chk("sel", 8'h1, sel);
        count = 0;
        repeat (16) begin
            @(negedge clk);
            count += fall;
        end
        chk("pulses", 8'h01, count[7:0]);
        chk("sel", 8'h0, sel);
    endtask
    // Idle counter must not advance while the enable is low
    task t_freeze;
        run = 1;
        repeat (12) @(negedge clk);
        chk("sel", 8'h1, sel);
        ce = 0;
        run = 0;
        repeat (60) @(negedge clk);
        chk("sel", 8'h1, sel);
        ce = 1;
        repeat (40) @(negedge clk);
        chk("sel", 8'h0, sel);
    endtask
    task t_midreset;
        run = 1;
        repeat (12) @(negedge clk);
        chk("sel", 8'h1, sel);
        t_reset();
    endtask
    initial begin
        t_reset();
        t_switch();
        t_freeze();
        t_midreset();
        conclude();
    end
    initial begin
        #20000 miscompares++;
        conclude();
    end
endmodule
